/* logic/pllcc_pkg.sv */
// Operation
// RULE1 - Loop output is crystal times 384.
// RULE2 - Core starts at loop output divided by 8.
// RULE3 - Modulator clock equals crystal, synchronous with core.
// RULE4 - Divider field selects loop over two-to-the-field.
// RULE5 - Halt bit stops oscillator during power-down.
// RULE6 - Read-only lock flag shows loop tracking crystal.
// RULE7 - Software polls lock after wake-up before use.
// RULE8 - Unlocked loop frequency is flagged as imprecise.
// RULE9 - Software writes zero to reserved bit 5.
// RULE10 - Bit 4 reads external-access pin latched at reset.
// RULE11 - Fast-interrupt bit runs service at fastest clock.
// RULE12 - Return from interrupt restores divided core clock.
// RULE13 - Control register resets to 03h.
// RULE14 - Interval counter clock comes from crystal oscillator.
// RULE15 - Clock switching produces no glitches or short pulses.
`default_nettype none
package pllcc_pkg;
	// Fixed ratio between loop output and crystal.
	localparam int unsigned PLLCC_LOOP_MULT = 384;
	// Width of the loop cycle counter that spans one crystal period.
	localparam int unsigned PLLCC_CNT_W = 9;
	// Last count of the crystal period.
	localparam logic [8:0] PLLCC_CNT_LAST = 9'(PLLCC_LOOP_MULT - 1);
	// Register indexes; the byte address is four times the index.
	localparam logic [7:0] PLLCC_IDX_CTRL = 8'hd7;
	localparam logic [7:0] PLLCC_IDX_STAT = 8'hd8;
	localparam logic [7:0] PLLCC_IDX_MASK = 8'hd9;
	// Control register reset value and field positions.
	localparam logic [7:0] PLLCC_CTRL_RST = 8'h03;
	localparam int unsigned PLLCC_B_HALT = 7;
	localparam int unsigned PLLCC_B_LOCK = 6;
	localparam int unsigned PLLCC_B_RSVD = 5;
	localparam int unsigned PLLCC_B_EA = 4;
	localparam int unsigned PLLCC_B_FAST_IRQ_CLOCK = 3;
	localparam int unsigned PLLCC_B_CD_HI = 2;
	// Status and mask layout: lock gained, lock lost, divider switched.
	localparam int unsigned PLLCC_EV_W = 3;
	localparam int unsigned PLLCC_EV_LOCK_UP = 0;
	localparam int unsigned PLLCC_EV_LOCK_DN = 1;
	localparam int unsigned PLLCC_EV_SWITCH = 2;
	localparam logic [2:0] PLLCC_EV_RST = 3'h0;
	// Edges after reset before the strap is caught; the synchronised pin settles at the fourth.
	localparam logic [2:0] PLLCC_STRAP_WAIT = 3'h5;
	// Synchronised pin positions.
	localparam int unsigned PLLCC_PIN_W = 3;
	localparam int unsigned PLLCC_PIN_LOCK = 0;
	localparam int unsigned PLLCC_PIN_XTAL = 1;
	localparam int unsigned PLLCC_PIN_EA = 2;
	// AHB transfer type of a valid single transfer.
	localparam logic [1:0] PLLCC_HTRANS_NONSEQ = 2'h2;
	// Captured address phase of one AHB transfer.
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] idx;
	} pllcc_aphase_t;
	// State of the divider switch sequencer.
	typedef enum logic [0:0] {
		PLLCC_RUN = 1'b0,
		PLLCC_SWITCH = 1'b1
	} pllcc_sw_t;
endpackage
`default_nettype wire

/* logic/pllcc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser per bit; the output follows once stages two and three agree.
module pllcc_sync3 #(
	parameter int unsigned W = 3
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output var logic [W-1:0] dout
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_r; // First stage, read only by the second.
			logic s2_r; // Second stage.
			logic s3_r; // Third stage.
			// Shift the pin through three flops and accept agreement.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					dout[g] <= 1'b0;
				end else if (ce) begin
					s1_r <= din[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						dout[g] <= s3_r;
					end
				end
			end
		end
	endgenerate
endmodule // pllcc_sync3
`default_nettype wire

/* logic/pllcc_top.sv */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Clock control: CLK stands for the loop output; the core, modulator and interval
// counter clocks leave as one-cycle enables so every switch happens on whole cycles.
module pllcc_top
	import pllcc_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic LOCK_DETECT,
	input wire logic XTAL_TICK,
	input wire logic EXT_ACCESS_PIN,
	input wire logic POWER_DOWN,
	input wire logic IRQ_ACTIVE,
	output logic CORE_CLK_EN,
	output logic MOD_CLK_EN,
	output logic TIC_CLK_EN,
	output logic OSC_HALT,
	output logic FREQ_IMPRECISE,
	output logic IRQ
);
	logic [PLLCC_PIN_W-1:0] pins; // Synchronised pin levels.
	logic [7:0] ctrl_r; // Writable control bits.
	logic ea_latch_r; // External-access level caught after reset.
	logic [2:0] strap_cnt_r; // Waits for the synchroniser to fill.
	logic lock_d_r; // Previous synchronised lock level.
	logic xtal_d_r; // Previous synchronised crystal level.
	logic [8:0] cnt_r; // Loop cycles within one crystal period.
	logic [2:0] act_div_r; // Divider now driving the core enable.
	logic [2:0] req_div; // Divider that should be in force.
	logic [7:0] act_mask; // Low counter bits that must be zero for a core pulse.
	logic core_hit; // Core pulse position under the active divider.
	pllcc_sw_t sw_r; // Switch sequencer state.
	pllcc_sw_t sw_nxt; // Its next value.
	logic [PLLCC_EV_W-1:0] stat_r; // Sticky event bits.
	logic [PLLCC_EV_W-1:0] mask_r; // Interrupt mask.
	logic [PLLCC_EV_W-1:0] ev; // Events of this cycle.
	pllcc_aphase_t ap_r; // Address phase in flight.
	logic take; // An address phase is accepted now.
	logic [7:0] aidx; // Register index of the current address.
	logic [7:0] ctrl_view; // Control register as read.
	logic stat_rd; // Status register read taken now.

	// Bring the three outside pins into the loop clock domain.
	pllcc_sync3 #(.W(PLLCC_PIN_W)) u_sync (
		.clk(CLK),
		.nrst(NRST),
		.ce(CE),
		.din({EXT_ACCESS_PIN, XTAL_TICK, LOCK_DETECT}),
		.dout(pins)
	);

	// AHB decode helpers; the index is the word address.
	assign take = HSEL && HREADY && (HTRANS == PLLCC_HTRANS_NONSEQ);
	assign aidx = HADDR[9:2];
	assign stat_rd = CE && take && !HWRITE && (aidx == PLLCC_IDX_STAT);

	// Readback of the control register with live lock and latched strap.
	always_comb begin
		ctrl_view = ctrl_r;
		ctrl_view[PLLCC_B_LOCK] = pins[PLLCC_PIN_LOCK]; // [RULE6]
		ctrl_view[PLLCC_B_RSVD] = 1'b0;
		ctrl_view[PLLCC_B_EA] = ea_latch_r; // [RULE10]
	end

	// Capture the address phase for the write that follows.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ap_r <= '0;
		end else if (CE) begin
			if (HREADY) begin
				ap_r.valid <= take;
				ap_r.write <= HWRITE;
				ap_r.idx <= aidx;
			end
		end
	end

	// Read data are formed at the address phase so they stand in the data phase.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			HRDATA <= 32'h0;
		end else if (CE) begin
			if (take && !HWRITE) begin
				if (aidx == PLLCC_IDX_CTRL) begin
					HRDATA <= {24'h0, ctrl_view};
				end else if (aidx == PLLCC_IDX_STAT) begin
					HRDATA <= {29'h0, stat_r};
				end else if (aidx == PLLCC_IDX_MASK) begin
					HRDATA <= {29'h0, mask_r};
				end else begin
					HRDATA <= 32'h0; // Unmapped reads return zero.
				end
			end
		end
	end

	// The slave never waits and never errors.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else if (CE) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Control register: only the halt, fast-interrupt and divider bits store.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_r <= PLLCC_CTRL_RST; // [RULE13] [RULE2]
		end else if (CE) begin
			if (ap_r.valid && ap_r.write && (ap_r.idx == PLLCC_IDX_CTRL)) begin
				ctrl_r <= HWDATA[7:0] & 8'h8f; // Lock, reserved and strap bits stay read-only.
			end
		end
	end

	// Interrupt mask register.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mask_r <= PLLCC_EV_RST;
		end else if (CE) begin
			if (ap_r.valid && ap_r.write && (ap_r.idx == PLLCC_IDX_MASK)) begin
				mask_r <= HWDATA[PLLCC_EV_W-1:0];
			end
		end
	end

	// Catch the external-access strap once the synchroniser has filled.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strap_cnt_r <= 3'h0;
			ea_latch_r <= 1'b0;
		end else if (CE) begin
			if (strap_cnt_r != PLLCC_STRAP_WAIT) begin
				strap_cnt_r <= strap_cnt_r + 3'h1;
				if (strap_cnt_r == PLLCC_STRAP_WAIT - 3'h1) begin
					ea_latch_r <= pins[PLLCC_PIN_EA]; // [RULE10]
				end
			end
		end
	end

	// Loop cycle counter; one wrap is one crystal period of 384 loop cycles.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_r <= 9'h0;
		end else if (CE) begin
			if (cnt_r == PLLCC_CNT_LAST) begin
				cnt_r <= 9'h0; // [RULE1]
			end else begin
				cnt_r <= cnt_r + 9'h1;
			end
		end
	end

	// Fast interrupt service forces divider zero; it falls back when service ends.
	assign req_div = (ctrl_r[PLLCC_B_FAST_IRQ_CLOCK] && IRQ_ACTIVE) ? 3'h0 :
		ctrl_r[PLLCC_B_CD_HI:0]; // [RULE11] [RULE12] [RULE4]
	assign act_mask = 8'((9'h1 << act_div_r) - 9'h1);
	// Core pulses sit on counter multiples of the divisor, aligned with the crystal.
	assign core_hit = (cnt_r[7:0] & act_mask) == 8'h0; // [RULE3]

	// Switch sequencer: a new divider is taken only on a core pulse boundary.
	always_comb begin
		sw_nxt = sw_r;
		case (sw_r)
			PLLCC_RUN: begin
				if (req_div != act_div_r) begin
					sw_nxt = PLLCC_SWITCH;
				end
			end
			PLLCC_SWITCH: begin
				if (core_hit) begin
					sw_nxt = PLLCC_RUN;
				end
			end
			default: begin
				sw_nxt = PLLCC_RUN;
			end
		endcase
	end

	// Sequencer state and the active divider.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sw_r <= PLLCC_RUN;
			act_div_r <= PLLCC_CTRL_RST[2:0]; // [RULE2]
		end else if (CE) begin
			sw_r <= sw_nxt;
			if (sw_r == PLLCC_SWITCH && core_hit) begin
				act_div_r <= req_div; // [RULE15]
			end
		end
	end

	// Clock enable outputs, each one loop cycle wide.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			CORE_CLK_EN <= 1'b0;
			MOD_CLK_EN <= 1'b0;
		end else if (CE) begin
			CORE_CLK_EN <= core_hit; // [RULE4] [RULE15]
			MOD_CLK_EN <= (cnt_r == 9'h0); // [RULE3]
		end
	end

	// Oscillator halt and the crystal-driven interval counter tick.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			xtal_d_r <= 1'b0;
			OSC_HALT <= 1'b0;
			TIC_CLK_EN <= 1'b0;
		end else if (CE) begin
			xtal_d_r <= pins[PLLCC_PIN_XTAL];
			OSC_HALT <= POWER_DOWN && ctrl_r[PLLCC_B_HALT]; // [RULE5]
			TIC_CLK_EN <= pins[PLLCC_PIN_XTAL] && !xtal_d_r &&
				!(POWER_DOWN && ctrl_r[PLLCC_B_HALT]); // [RULE14] [RULE5]
		end
	end

	// Flag the loop output as imprecise while unlocked.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			lock_d_r <= 1'b0;
			FREQ_IMPRECISE <= 1'b1;
		end else if (CE) begin
			lock_d_r <= pins[PLLCC_PIN_LOCK];
			FREQ_IMPRECISE <= !pins[PLLCC_PIN_LOCK]; // [RULE8]
		end
	end

	// Events: lock edges and a completed divider switch.
	assign ev[PLLCC_EV_LOCK_UP] = pins[PLLCC_PIN_LOCK] && !lock_d_r;
	assign ev[PLLCC_EV_LOCK_DN] = !pins[PLLCC_PIN_LOCK] && lock_d_r;
	assign ev[PLLCC_EV_SWITCH] = (sw_r == PLLCC_SWITCH) && core_hit;

	// Sticky status, cleared by a read; an event in the same cycle wins.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			stat_r <= PLLCC_EV_RST;
		end else if (CE) begin
			stat_r <= (stat_rd ? PLLCC_EV_RST : stat_r) | ev;
		end
	end

	// Level interrupt while any unmasked status bit is set.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			IRQ <= 1'b0;
		end else if (CE) begin
			IRQ <= |(((stat_rd ? PLLCC_EV_RST : stat_r) | ev) & mask_r);
		end
	end

	// Checks.
	sequence s_ctrl_wr;
		ap_r.valid && ap_r.write && (ap_r.idx == PLLCC_IDX_CTRL) && CE;
	endsequence
	sequence s_switch_done;
		(sw_r == PLLCC_SWITCH) && core_hit && CE;
	endsequence

	property p_mod_period; // Modulator pulse every 384 loop cycles.
		@(posedge CLK) disable iff (!NRST)
		(CE && cnt_r == PLLCC_CNT_LAST) ##1 ((cnt_r == 9'h0) && CE) |=> MOD_CLK_EN;
	endproperty
	a_mod_period: assert property (p_mod_period) else $error("modulator pulse missing"); // [RULE1]

	property p_aligned; // Every modulator pulse coincides with a core pulse.
		@(posedge CLK) disable iff (!NRST)
		MOD_CLK_EN |-> CORE_CLK_EN;
	endproperty
	a_aligned: assert property (p_aligned) else $error("core and modulator out of step"); // [RULE3]

	property p_div_spacing; // With divider 1, no core pulse follows another in the next cycle.
		@(posedge CLK) disable iff (!NRST)
		(CE && core_hit && sw_r == PLLCC_RUN && act_div_r == 3'h1 && cnt_r != PLLCC_CNT_LAST)
			|-> ##1 !core_hit;
	endproperty
	a_div_spacing: assert property (p_div_spacing) else $error("core divide wrong"); // [RULE4]

	property p_reset_div; // Divider 3 after reset.
		@(posedge CLK) $rose(NRST) |-> (act_div_r == 3'h3) && (ctrl_r == PLLCC_CTRL_RST);
	endproperty
	a_reset_div: assert property (p_reset_div) else $error("reset value wrong"); // [RULE13]

	property p_halt; // Halt output follows power-down and the halt bit.
		@(posedge CLK) disable iff (!NRST)
		(CE && POWER_DOWN && ctrl_r[PLLCC_B_HALT]) |=> OSC_HALT && !TIC_CLK_EN;
	endproperty
	a_halt: assert property (p_halt) else $error("oscillator not halted"); // [RULE5]

	property p_lock_read; // Control reads show the live lock level.
		@(posedge CLK) disable iff (!NRST)
		(CE && take && !HWRITE && aidx == PLLCC_IDX_CTRL)
			|=> HRDATA[PLLCC_B_LOCK] == $past(pins[PLLCC_PIN_LOCK]);
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock readback wrong"); // [RULE6]

	property p_imprecise; // Imprecise flag is the inverse of lock.
		@(posedge CLK) disable iff (!NRST)
		CE |=> FREQ_IMPRECISE == !$past(pins[PLLCC_PIN_LOCK]);
	endproperty
	a_imprecise: assert property (p_imprecise) else $error("imprecise flag wrong"); // [RULE8]

	property p_ea_ro; // Writes never move the strap bit.
		@(posedge CLK) disable iff (!NRST)
		(s_ctrl_wr and (strap_cnt_r == PLLCC_STRAP_WAIT)) |=> $stable(ea_latch_r);
	endproperty
	a_ea_ro: assert property (p_ea_ro) else $error("strap bit changed by write"); // [RULE10]

	property p_fast; // Fast service reaches divider zero within one crystal period.
		@(posedge CLK) disable iff (!NRST)
		(CE && ctrl_r[PLLCC_B_FAST_IRQ_CLOCK] && IRQ_ACTIVE)[*8] |-> ##[0:384]
			(act_div_r == 3'h0 || !IRQ_ACTIVE || !ctrl_r[PLLCC_B_FAST_IRQ_CLOCK] || !CE);
	endproperty
	a_fast: assert property (p_fast) else $error("fast interrupt clock not applied"); // [RULE11]

	property p_restore; // Divider only changes on a pulse boundary.
		@(posedge CLK) disable iff (!NRST)
		(CE && !$stable(act_div_r)) |-> $past(core_hit) && $past(sw_r == PLLCC_SWITCH);
	endproperty
	a_restore: assert property (p_restore) else $error("divider switched off boundary"); // [RULE15]

	property p_switch_event; // A completed switch sets its status bit.
		@(posedge CLK) disable iff (!NRST)
		s_switch_done |=> stat_r[PLLCC_EV_SWITCH];
	endproperty
	a_switch_event: assert property (p_switch_event) else $error("switch event lost"); // [RULE12]

	property p_tic; // Interval tick needs a crystal edge.
		@(posedge CLK) disable iff (!NRST)
		TIC_CLK_EN |-> $past(xtal_d_r) == 1'b0;
	endproperty
	a_tic: assert property (p_tic) else $error("interval tick without crystal edge"); // [RULE14]

	property p_default; // Unchanged default keeps a pulse every 8 cycles.
		@(posedge CLK) disable iff (!NRST)
		(CE && CORE_CLK_EN && act_div_r == 3'h3 && $past(act_div_r) == 3'h3 &&
			sw_r == PLLCC_RUN) ##1 CE[*7]
			|-> !$past(CORE_CLK_EN) ##1 CORE_CLK_EN;
	endproperty
	a_default: assert property (p_default) else $error("default divide wrong"); // [RULE2]
endmodule // pllcc_top
`default_nettype wire

/* sim/pllcc_xtal_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural watch crystal together with the loop lock detector that follows it.
module pllcc_xtal_model #(
	parameter int HALF_NS = 7680,
	parameter int LOCK_TICKS = 4
) (
	input wire logic osc_halt,
	output logic xtal_tick,
	output logic lock_detect
);
	// Rising crystal edges seen since the oscillator last started, held once it reaches LOCK_TICKS.
	int n_tick;
	// One crystal period is 384 loop cycles of 40 ns; a halted crystal stands still.
	initial begin
		xtal_tick = 1'b0;
		#3;
		forever begin
			#HALF_NS;
			if (!osc_halt) begin
				xtal_tick = ~xtal_tick;
			end
		end
	end
	// Lock comes after a few steady periods and is lost at once when the crystal stops.
	initial begin
		lock_detect = 1'b0;
		n_tick = 0;
		forever begin
			@(posedge xtal_tick or posedge osc_halt);
			if (osc_halt) begin
				n_tick = 0;
				lock_detect = 1'b0;
			end else if (n_tick < LOCK_TICKS) begin
				n_tick++;
			end else begin
				lock_detect = 1'b1;
			end
		end
	end
endmodule // pllcc_xtal_model
`default_nettype wire

/* sim/pll_core_clock_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: bus master, crystal model and a small register model.
module pll_core_clock_control_test;
	import pllcc_pkg::*;
	// Byte addresses of the three registers.
	localparam logic [31:0] A_CTRL = {22'h0, PLLCC_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_STAT = {22'h0, PLLCC_IDX_STAT, 2'h0};
	localparam logic [31:0] A_MASK = {22'h0, PLLCC_IDX_MASK, 2'h0};
	logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, strap, ea_pin, pdown, irq_act;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, ens;
	logic tick, lock, core_en, mod_en, tic_en, osc_halt, imprecise, irq;
	int n_fail, checks, seed, ctrl_m, g, v;
	// The single slave drives the bus ready.
	assign hready = hreadyout;
	assign ens = {tic_en, mod_en, core_en};
	pllcc_top dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .LOCK_DETECT(lock),
		.XTAL_TICK(tick), .EXT_ACCESS_PIN(ea_pin), .POWER_DOWN(pdown), .IRQ_ACTIVE(irq_act),
		.CORE_CLK_EN(core_en), .MOD_CLK_EN(mod_en), .TIC_CLK_EN(tic_en), .OSC_HALT(osc_halt),
		.FREQ_IMPRECISE(imprecise), .IRQ(irq));
	pllcc_xtal_model xtal (.osc_halt(osc_halt), .xtal_tick(tick), .lock_detect(lock));
	// The 25 MHz clock.
	always #20 clk = ~clk;
	// Prints the verdict and ends the run.
	task automatic results;
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (e !== s) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// A used-up wait bound counts as a mismatch and closes the run.
	task automatic lim(input int n);
		if (n >= 1000) begin
			n_fail++;
			results();
		end
	endtask
	// Waits for a rising edge with ready high.
	task automatic step_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 1000);
		lim(n);
	endtask
	// One single AHB word transfer; read data lands in rd.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= PLLCC_HTRANS_NONSEQ;
		hwrite <= wr;
		step_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		step_rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// Writes the control register and updates the model of its writable bits.
	task automatic wctl(input int val);
		ctrl_m = val & 32'h8f;
		bus(1'b1, A_CTRL, 32'(val));
	endtask
	// Expected control read for a given lock state.
	function automatic logic [31:0] xc(input int lk);
		return 32'(ctrl_m) | 32'(lk << 6) | {27'h0, strap, 4'h0};
	endfunction
	// Cycles between two pulses of the chosen enable.
	task automatic gap(input int w, output int c);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ens[w] !== 1'b1 && n < 1000);
		lim(n);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (ens[w] !== 1'b1 && c < 1000);
		lim(c);
	endtask
	// Counts interval counter pulses over two crystal periods.
	task automatic count_tic(output int c);
		c = 0;
		repeat (768) begin
			@(negedge clk);
			if (tic_en === 1'b1) c++;
		end
	endtask
	// Polls the lock flag until it reads one.
	task automatic poll_lock;
		int k;
		k = 0;
		do begin
			bus(1'b0, A_CTRL, 32'h0);
			k++;
		end while (rd[6] !== 1'b1 && k < 1000);
		lim(k);
	endtask
	// Main sequence.
	initial begin
		seed = 32'haab1;
		clk = 1'b0;
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pdown = 1'b0;
		irq_act = 1'b0;
		strap = 1'($random(seed));
		ea_pin = strap;
		n_fail = 0;
		checks = 0;
		ctrl_m = 3;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		ea_pin <= ~strap;
		chk("imprecise", 32'h1, {31'h0, imprecise});
		bus(1'b0, A_CTRL, 32'h0);
		chk("ctrl_reset", xc(0), rd);
		bus(1'b0, A_MASK, 32'h0);
		chk("mask_reset", 32'h0, rd);
		gap(0, g);
		chk("core_gap", 32'h8, 32'(g));
		gap(1, g);
		chk("mod_gap", 32'd384, 32'(g));
		poll_lock();
		chk("imprecise", 32'h0, {31'h0, imprecise});
		bus(1'b0, A_STAT, 32'h0);
		chk("stat_lock_up", 32'h1, rd);
		bus(1'b1, 32'h10, 32'hff);
		bus(1'b0, 32'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		for (int d = 0; d < 8; d++) begin
			v = ($random(seed) & 32'hd0) | d;
			wctl(v);
			repeat (300) @(posedge clk);
			gap(0, g);
			chk("core_gap", 32'(1 << d), 32'(g));
			bus(1'b0, A_CTRL, 32'h0);
			chk("ctrl", xc(1), rd);
			bus(1'b0, A_STAT, 32'h0);
			chk("stat_switch", 32'h4, rd);
		end
		gap(1, g);
		chk("mod_gap", 32'd384, 32'(g));
		bus(1'b1, A_MASK, 32'h4);
		wctl(32'h0d);
		repeat (300) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b0, A_STAT, 32'h0);
		chk("stat_switch", 32'h4, rd);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		gap(0, g);
		chk("core_gap", 32'd32, 32'(g));
		@(posedge clk);
		irq_act <= 1'b1;
		repeat (300) @(posedge clk);
		gap(0, g);
		chk("core_gap_fast", 32'h1, 32'(g));
		@(posedge clk);
		irq_act <= 1'b0;
		repeat (300) @(posedge clk);
		gap(0, g);
		chk("core_gap", 32'd32, 32'(g));
		bus(1'b1, A_MASK, 32'h0);
		bus(1'b0, A_STAT, 32'h0);
		@(posedge clk);
		pdown <= 1'b1;
		repeat (10) @(posedge clk);
		chk("osc_halt", 32'h0, {31'h0, osc_halt});
		count_tic(g);
		chk("tic_count", 32'h2, 32'(g));
		wctl(32'h85);
		repeat (20) @(posedge clk);
		chk("osc_halt", 32'h1, {31'h0, osc_halt});
		chk("imprecise", 32'h1, {31'h0, imprecise});
		chk("irq_masked", 32'h0, {31'h0, irq});
		count_tic(g);
		chk("tic_count", 32'h0, 32'(g));
		bus(1'b0, A_CTRL, 32'h0);
		chk("ctrl_unlocked", xc(0), rd);
		bus(1'b1, A_MASK, 32'h2);
		repeat (3) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b0, A_STAT, 32'h0);
		chk("stat_lock_dn", 32'h2, rd & 32'h2);
		@(posedge clk);
		pdown <= 1'b0;
		poll_lock();
		chk("imprecise", 32'h0, {31'h0, imprecise});
		chk("osc_halt", 32'h0, {31'h0, osc_halt});
		results();
	end
endmodule // pll_core_clock_control_test
`default_nettype wire
